// file: verilog/rdc_sequencer.sv
// Overview of operation
// - sense external field before every NFC send
// - response slots random 0..3, forced 0 variant
// - collision skips sending, raises NFC event
// - NFC sends own field, host bit ignored
// - initial avoidance uses 302us, 37.76us, 5.11ms
// - response avoidance uses 151us and 84us
// - field held 65us after last data
// - end-of-send event when field drops
// - NFC sends need nfc mode and oscillator
// - mask drops receive path and framing
// - unmask raises path, beats receive timer
// - receive restarts 40us after send end
// - receive entered automatically after each send
// - mask commands need receiver running
// - convert input into result within 42us
// - measure RF through detector, absolute mode
// - squelch within 500us; clear always accepted
// - regulator steps 100mV from 3.4V floor 2.4V
// - regulator adjust refused under external select
// - modulation depth calibrated within 10ms
// - antenna calibrate 400us, check 42us
// - clear peak strength on path rise, command
// - transparent on enable fall while held low
`timescale 1ns/100ps
module rdc_sequencer
  import rdc_pkg::*;
#(
  parameter int unsigned IDT_CYC  = cyc_min(INITIAL_DELAY_TIME_NS),
  parameter int unsigned RWF_CYC  = cyc_min(RF_WAITING_TIME_NS),
  parameter int unsigned IRFG_CYC = cyc_min(INITIAL_GUARD_TIME_NS),
  parameter int unsigned ADT_CYC  = cyc_min(ACTIVE_DELAY_TIME_NS),
  parameter int unsigned ARFG_CYC = cyc_min(ACTIVE_GUARD_TIME_NS),
  parameter int unsigned GAS_CYC  = cyc_min(POST_SEND_FIELD_HOLD_TIME_NS),
  parameter int unsigned RXD_CYC  = cyc_min(T_RXD_NS),
  parameter int unsigned ADC_CYC  = cyc_max(T_ADC_NS),
  parameter int unsigned SQL_CYC  = cyc_max(T_SQL_NS),
  parameter int unsigned STEP_CYC = cyc_min(T_STEP_NS),
  parameter int unsigned MOD_CYC  = cyc_max(T_MOD_NS),
  parameter int unsigned ANT_CYC  = cyc_max(T_ANT_NS),
  parameter int unsigned CHK_CYC  = cyc_max(T_CHK_NS)
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              link_clk,
  input  wire logic              link_rst_b,
  input  wire logic              cmd_strobe,
  input  wire logic [CMD_W-1:0]  cmd_code,
  input  wire logic              serial_enable_line,
  input  wire logic              nfc_mode,
  input  wire logic              osc_ready,
  input  wire logic              rx_enabled,
  input  wire logic              tx_enabled,
  input  wire logic              reg_ext_select,
  input  wire logic              ext_field_detect,
  input  wire logic              tx_data_done,
  input  wire logic              rail_margin_ok,
  input  wire logic [DATA_W-1:0] adc_sample,
  input  wire logic [DATA_W-1:0] mod_depth_meas,
  output logic                   rf_field_on,
  output logic                   tx_start,
  output logic                   rx_on,
  output logic                   framing_en,
  output logic                   received_strength_indicator_clear,
  output logic                   irq_nfc_event,
  output logic                   irq_end_tx,
  output logic                   adc_rf_select,
  output logic [DATA_W-1:0]      adc_result,
  output logic                   squelch_on,
  output logic                   force_txrx,
  output logic [REG_W-1:0]       reg_setting,
  output logic [DATA_W-1:0]      mod_depth_result,
  output logic                   ant_cal_active,
  output logic                   transparent_on,
  output logic                   cmd_busy,
  output logic                   cmd_reject
);

  localparam int unsigned CNT_LIM = 2 ** CNT_W;

  if (IDT_CYC < 1 || RWF_CYC < 1 || IRFG_CYC < 1 || ADT_CYC < 1 || ARFG_CYC < 1 ||
      GAS_CYC < 1 || RXD_CYC < 1 || ADC_CYC < 1 || SQL_CYC < 1 || STEP_CYC < 1 ||
      MOD_CYC < 1 || ANT_CYC < 1 || CHK_CYC < 1 || IRFG_CYC >= CNT_LIM ||
      MOD_CYC >= CNT_LIM || IDT_CYC >= CNT_LIM || SQL_CYC >= CNT_LIM) begin : g_bad
    $error("rdc_sequencer: timing count out of range");
  end

  localparam logic [CNT_W-1:0] L_IDT  = CNT_W'(IDT_CYC - 1);
  localparam logic [CNT_W-1:0] L_RWF  = CNT_W'(RWF_CYC - 1);
  localparam logic [CNT_W-1:0] L_IRFG = CNT_W'(IRFG_CYC - 1);
  localparam logic [CNT_W-1:0] L_ADT  = CNT_W'(ADT_CYC - 1);
  localparam logic [CNT_W-1:0] L_ARFG = CNT_W'(ARFG_CYC - 1);
  localparam logic [CNT_W-1:0] L_GAS  = CNT_W'(GAS_CYC - 1);
  localparam logic [CNT_W-1:0] L_RXD  = CNT_W'(RXD_CYC - 1);
  localparam logic [CNT_W-1:0] L_ADC  = CNT_W'(ADC_CYC - 1);
  localparam logic [CNT_W-1:0] L_SQL  = CNT_W'(SQL_CYC - 1);
  localparam logic [CNT_W-1:0] L_STEP = CNT_W'(STEP_CYC - 1);
  localparam logic [CNT_W-1:0] L_MOD  = CNT_W'(MOD_CYC - 1);
  localparam logic [CNT_W-1:0] L_ANT  = CNT_W'(ANT_CYC - 1);
  localparam logic [CNT_W-1:0] L_CHK  = CNT_W'(CHK_CYC - 1);

  function automatic logic is_nfc_cmd(input logic [CMD_W-1:0] c);
    return (c == CMD_NFC_INIT) || (c == CMD_NFC_RESP) || (c == CMD_NFC_RESP0);
  endfunction

  function automatic logic is_osc_cmd(input logic [CMD_W-1:0] c);
    return (c == CMD_ADC) || (c == CMD_MEAS_RF) || (c == CMD_CAL_MOD) ||
           (c == CMD_CAL_ANT) || (c == CMD_CHK_ANT);
  endfunction

  // command transport from the link domain
  logic [CMD_W-1:0] link_code;
  logic             link_tgl;

  rdc_link_capture u_link (
    .link_clk   (link_clk),
    .link_rst_b (link_rst_b),
    .cmd_strobe (cmd_strobe),
    .cmd_code   (cmd_code),
    .code_hold  (link_code),
    .cmd_toggle (link_tgl)
  );

  logic tgl_m_r, tgl_s_r, tgl_d_r;
  logic sen_m_r, sen_s_r, sen_d_r;
  logic fld_m_r, fld_s_r;
  logic rail_m_r, rail_s_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      {tgl_m_r, tgl_s_r, tgl_d_r} <= 3'h0;
      {sen_m_r, sen_s_r, sen_d_r} <= 3'h7;
      {fld_m_r, fld_s_r}          <= 2'h0;
      {rail_m_r, rail_s_r}        <= 2'h0;
    end else begin
      {tgl_m_r, tgl_s_r, tgl_d_r} <= {link_tgl, tgl_m_r, tgl_s_r};
      {sen_m_r, sen_s_r, sen_d_r} <= {serial_enable_line, sen_m_r, sen_s_r};
      {fld_m_r, fld_s_r}          <= {ext_field_detect, fld_m_r};
      {rail_m_r, rail_s_r}        <= {rail_margin_ok, rail_m_r};
    end
  end

  rdc_state_t       state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [SLOT_W:0]  slots_r, slots_nxt;
  logic             init_r;
  logic [CMD_W-1:0] op_r;
  logic [DATA_W-1:0] lfsr_r;

  // code is two ref cycles old when the toggle edge shows, so it is settled
  wire cmd_fire = tgl_s_r ^ tgl_d_r;
  wire idle     = (state_r == ST_IDLE);
  wire cnt_zero = (cnt_r == '0);

  wire acc_nfc    = cmd_fire && idle && is_nfc_cmd(link_code) && nfc_mode && osc_ready;
  wire acc_mask   = cmd_fire && (link_code == CMD_MASK_RX) && rx_enabled;
  wire acc_unmask = cmd_fire && (link_code == CMD_UNMASK_RX) && rx_enabled;
  wire acc_osc    = cmd_fire && idle && is_osc_cmd(link_code) && osc_ready;
  wire acc_sql    = cmd_fire && idle && (link_code == CMD_SQUELCH) && tx_enabled && rx_enabled;
  wire acc_clrsql = cmd_fire && (link_code == CMD_CLR_SQUELCH);
  wire acc_adj    = cmd_fire && idle && (link_code == CMD_ADJ_REG) && osc_ready &&
                    !reg_ext_select;
  wire acc_received_strength_indicator   = cmd_fire && (link_code == CMD_CLR_RECEIVED_STRENGTH_INDICATOR);
  wire acc_transp = cmd_fire && idle && (link_code == CMD_TRANSP) && tx_enabled && rx_enabled;
  wire acc_timed  = acc_osc || acc_sql;
  wire accepted   = acc_nfc || acc_mask || acc_unmask || acc_timed || acc_clrsql ||
                    acc_adj || acc_received_strength_indicator || acc_transp;
  wire refused    = cmd_fire && !accepted;

  wire [SLOT_W:0] slot_pick =
    (link_code == CMD_NFC_INIT)  ? (SLOT_W+1)'(1) :
    (link_code == CMD_NFC_RESP0) ? '0 :
                                   {1'b0, lfsr_r[SLOT_W-1:0]};
  wire [CNT_W-1:0] first_wait = (link_code == CMD_NFC_INIT) ? L_IDT : L_ADT;
  wire [CNT_W-1:0] guard_wait = init_r ? L_IRFG : L_ARFG;
  wire [CNT_W-1:0] timed_wait =
    (link_code == CMD_ADC)     ? L_ADC :
    (link_code == CMD_MEAS_RF) ? L_ADC :
    (link_code == CMD_SQUELCH) ? L_SQL :
    (link_code == CMD_CAL_MOD) ? L_MOD :
    (link_code == CMD_CAL_ANT) ? L_ANT : L_CHK;

  logic [REG_W-1:0] reg_setting_r;
  logic             force_txrx_r;

  wire sensing   = (state_r == ST_DELAY) || (state_r == ST_SLOT);
  wire collision = sensing && fld_s_r;
  wire hold_end  = (state_r == ST_HOLD) && cnt_zero;
  wire busy_end  = (state_r == ST_BUSY) && cnt_zero;
  wire adj_check = (state_r == ST_ADJ) && cnt_zero;
  wire adj_done  = adj_check && (rail_s_r || reg_setting_r == REG_FLOOR);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 1'b1;
    slots_nxt = slots_r;
    unique case (state_r)
      ST_IDLE: begin
        if (acc_nfc) begin
          state_nxt = ST_DELAY;
          cnt_nxt   = first_wait;
          slots_nxt = slot_pick;
        end else if (acc_timed) begin
          state_nxt = ST_BUSY;
          cnt_nxt   = timed_wait;
        end else if (acc_adj) begin
          state_nxt = ST_ADJ;
          cnt_nxt   = L_STEP;
        end
      end
      ST_DELAY, ST_SLOT: begin
        if (collision) begin
          state_nxt = ST_IDLE;
        end else if (cnt_zero && slots_r == '0) begin
          state_nxt = ST_GUARD;
          cnt_nxt   = guard_wait;
        end else if (cnt_zero) begin
          state_nxt = ST_SLOT;
          cnt_nxt   = L_RWF;
          slots_nxt = slots_r - 1'b1;
        end
      end
      ST_GUARD: begin
        if (cnt_zero) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_data_done) begin
          state_nxt = ST_HOLD;
          cnt_nxt   = L_GAS;
        end
      end
      ST_HOLD: begin
        if (cnt_zero) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (cnt_zero) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ADJ: begin
        if (adj_done) begin
          state_nxt = ST_IDLE;
        end else if (adj_check) begin
          cnt_nxt = L_STEP;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      slots_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      slots_r <= slots_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      init_r <= 1'b0;
      op_r   <= '0;
      lfsr_r <= LFSR_SEED;
    end else begin
      lfsr_r <= {1'b0, lfsr_r[DATA_W-1:1]} ^ (lfsr_r[0] ? LFSR_TAPS : '0);
      if (acc_nfc) begin
        init_r <= (link_code == CMD_NFC_INIT);
      end
      if (acc_timed) begin
        op_r <= link_code;
      end
    end
  end

  // field owned by the sequencer in nfc mode; host enable only outside it
  wire seq_field_nxt = (state_nxt == ST_GUARD) || (state_nxt == ST_SEND) ||
                       (state_nxt == ST_HOLD);
  wire field_nxt     = nfc_mode ? seq_field_nxt : (tx_enabled || force_txrx_r);

  // receive path: unmask beats the post-send timer
  logic             rx_path_r, rxw_act_r, rx_on_r;
  logic [CNT_W-1:0] rxw_cnt_r;
  wire rxw_end     = rxw_act_r && (rxw_cnt_r == '0);
  wire rx_path_nxt = acc_unmask ? 1'b1 :
                     acc_mask   ? 1'b0 :
                     acc_nfc    ? 1'b0 :
                     rxw_end    ? 1'b1 : rx_path_r;
  wire rx_on_nxt   = rx_path_nxt && rx_enabled;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_path_r <= 1'b0;
      rxw_act_r <= 1'b0;
      rxw_cnt_r <= '0;
    end else begin
      rx_path_r <= rx_path_nxt;
      if (acc_unmask || acc_mask || rxw_end) begin
        rxw_act_r <= 1'b0;
      end else if (hold_end) begin
        rxw_act_r <= 1'b1;
        rxw_cnt_r <= L_RXD;
      end else if (rxw_act_r) begin
        rxw_cnt_r <= rxw_cnt_r - 1'b1;
      end
    end
  end

  logic rf_field_on_r, seq_field_r, tx_start_r, framing_en_r, received_strength_indicator_clear_r;
  logic irq_nfc_event_r, irq_end_tx_r, cmd_busy_r, cmd_reject_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rf_field_on_r   <= 1'b0;
      seq_field_r     <= 1'b0;
      tx_start_r      <= 1'b0;
      rx_on_r         <= 1'b0;
      framing_en_r    <= 1'b0;
      received_strength_indicator_clear_r    <= 1'b0;
      irq_nfc_event_r <= 1'b0;
      irq_end_tx_r    <= 1'b0;
      cmd_busy_r      <= 1'b0;
      cmd_reject_r    <= 1'b0;
    end else begin
      rf_field_on_r   <= field_nxt;
      seq_field_r     <= seq_field_nxt;
      tx_start_r      <= (state_r == ST_GUARD) && cnt_zero;
      rx_on_r         <= rx_on_nxt;
      framing_en_r    <= rx_path_nxt;
      received_strength_indicator_clear_r    <= (rx_on_nxt && !rx_on_r) || acc_received_strength_indicator;
      irq_nfc_event_r <= collision;
      irq_end_tx_r    <= hold_end;
      cmd_busy_r      <= (state_nxt != ST_IDLE);
      cmd_reject_r    <= refused;
    end
  end

  logic              adc_rf_select_r, squelch_on_r, ant_cal_r;
  logic [DATA_W-1:0] adc_result_r, mod_depth_r;
  logic              armed_r, transparent_r;
  wire sen_fall = !sen_s_r && sen_d_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      adc_rf_select_r <= 1'b0;
      adc_result_r    <= '0;
      squelch_on_r    <= 1'b0;
      force_txrx_r    <= 1'b0;
      reg_setting_r   <= REG_TOP;
      mod_depth_r     <= '0;
      ant_cal_r       <= 1'b0;
      armed_r         <= 1'b0;
      transparent_r   <= 1'b0;
    end else begin
      if (acc_osc) begin
        adc_rf_select_r <= (link_code == CMD_MEAS_RF);
        ant_cal_r       <= (link_code == CMD_CAL_ANT);
      end else if (busy_end) begin
        adc_rf_select_r <= 1'b0;
        ant_cal_r       <= 1'b0;
      end
      if (busy_end && (op_r == CMD_ADC || op_r == CMD_MEAS_RF)) begin
        adc_result_r <= adc_sample;
      end
      if (busy_end && op_r == CMD_CAL_MOD) begin
        mod_depth_r <= mod_depth_meas;
      end
      if (busy_end && op_r == CMD_SQUELCH) begin
        squelch_on_r <= 1'b1;
      end else if (acc_clrsql) begin
        squelch_on_r <= 1'b0;
      end
      if (acc_adj) begin
        force_txrx_r  <= 1'b1;
        reg_setting_r <= REG_TOP;
      end else if (adj_done) begin
        force_txrx_r <= 1'b0;
      end else if (adj_check) begin
        reg_setting_r <= reg_setting_r - 1'b1;
      end
      if (acc_transp) begin
        armed_r <= 1'b1;
      end else if (sen_fall && armed_r) begin
        armed_r       <= 1'b0;
        transparent_r <= 1'b1;
      end else if (sen_s_r) begin
        transparent_r <= 1'b0;
      end
    end
  end

  assign rf_field_on      = rf_field_on_r;
  assign tx_start         = tx_start_r;
  assign rx_on            = rx_on_r;
  assign framing_en       = framing_en_r;
  assign received_strength_indicator_clear       = received_strength_indicator_clear_r;
  assign irq_nfc_event    = irq_nfc_event_r;
  assign irq_end_tx       = irq_end_tx_r;
  assign adc_rf_select    = adc_rf_select_r;
  assign adc_result       = adc_result_r;
  assign squelch_on       = squelch_on_r;
  assign force_txrx       = force_txrx_r;
  assign reg_setting      = reg_setting_r;
  assign mod_depth_result = mod_depth_r;
  assign ant_cal_active   = ant_cal_r;
  assign transparent_on   = transparent_r;
  assign cmd_busy         = cmd_busy_r;
  assign cmd_reject       = cmd_reject_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_nfc_refused: assert property (cmd_fire && idle && is_nfc_cmd(link_code) &&
      !(nfc_mode && osc_ready) |=> state_r == ST_IDLE && cmd_reject_r)
    else $error("nfc send taken without nfc mode or oscillator");
  a_collision_skip: assert property (collision |=> irq_nfc_event_r && !seq_field_r &&
      state_r == ST_IDLE)
    else $error("collision did not abort the send");
  a_sense_field_off: assert property (sensing |-> !seq_field_r)
    else $error("field on while sensing for collision");
  a_end_at_drop: assert property (irq_end_tx_r |-> !seq_field_r && $past(seq_field_r))
    else $error("end-of-send event not at field drop");
  a_hold_guard: assert property ($rose(state_r == ST_HOLD) |-> seq_field_r [*8])
    else $error("field dropped during hold");
  a_mask_drop: assert property (acc_mask && !acc_unmask |=> !rx_on_r && !framing_en_r)
    else $error("mask left receive path on");
  a_unmask_rise: assert property (acc_unmask |=> rx_on_r && framing_en_r && !rxw_act_r)
    else $error("unmask did not open receive path");
  a_adj_refused: assert property (cmd_fire && idle && link_code == CMD_ADJ_REG &&
      reg_ext_select |=> state_r == ST_IDLE && !force_txrx_r)
    else $error("regulator adjust taken under external select");
  a_received_strength_indicator_on_rise: assert property ($rose(rx_on_r) |-> received_strength_indicator_clear_r)
    else $error("peak strength not cleared on path rise");
  a_reg_floor: assert property (adj_check && !rail_s_r && reg_setting_r != REG_FLOOR
      |=> reg_setting_r == $past(reg_setting_r) - 1'b1)
    else $error("regulator did not step down");

endmodule

// file: verilog/rdc_pkg.sv
package rdc_pkg;

  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CMD_W   = 6;
  localparam int unsigned CNT_W   = 21;
  localparam int unsigned SLOT_W  = 2;
  localparam int unsigned REG_W   = 4;
  localparam int unsigned DATA_W  = 8;

  // direct command codes
  localparam logic [CMD_W-1:0] CMD_NFC_INIT    = 6'h08;
  localparam logic [CMD_W-1:0] CMD_NFC_RESP    = 6'h09;
  localparam logic [CMD_W-1:0] CMD_NFC_RESP0   = 6'h0A;
  localparam logic [CMD_W-1:0] CMD_MASK_RX     = 6'h10;
  localparam logic [CMD_W-1:0] CMD_UNMASK_RX   = 6'h11;
  localparam logic [CMD_W-1:0] CMD_ADC         = 6'h12;
  localparam logic [CMD_W-1:0] CMD_MEAS_RF     = 6'h13;
  localparam logic [CMD_W-1:0] CMD_SQUELCH     = 6'h14;
  localparam logic [CMD_W-1:0] CMD_CLR_SQUELCH = 6'h15;
  localparam logic [CMD_W-1:0] CMD_ADJ_REG     = 6'h16;
  localparam logic [CMD_W-1:0] CMD_CAL_MOD     = 6'h17;
  localparam logic [CMD_W-1:0] CMD_CAL_ANT     = 6'h18;
  localparam logic [CMD_W-1:0] CMD_CHK_ANT     = 6'h19;
  localparam logic [CMD_W-1:0] CMD_CLR_RECEIVED_STRENGTH_INDICATOR    = 6'h1A;
  localparam logic [CMD_W-1:0] CMD_TRANSP      = 6'h1C;

  // times in ns
  localparam int unsigned INITIAL_DELAY_TIME_NS   = 302_000;
  localparam int unsigned RF_WAITING_TIME_NS   = 37_760;
  localparam int unsigned INITIAL_GUARD_TIME_NS  = 5_110_000;
  localparam int unsigned ACTIVE_DELAY_TIME_NS   = 151_000;
  localparam int unsigned ACTIVE_GUARD_TIME_NS  = 84_000;
  localparam int unsigned POST_SEND_FIELD_HOLD_TIME_NS   = 65_000;
  localparam int unsigned T_RXD_NS   = 40_000;
  localparam int unsigned T_ADC_NS   = 42_000;
  localparam int unsigned T_SQL_NS   = 500_000;
  localparam int unsigned T_STEP_NS  = 300_000;
  localparam int unsigned T_MOD_NS   = 10_000_000;
  localparam int unsigned T_ANT_NS   = 400_000;
  localparam int unsigned T_CHK_NS   = 42_000;

  // regulator code counts steps above the floor
  localparam int unsigned REG_MAX_MV  = 3400;
  localparam int unsigned REG_MIN_MV  = 2400;
  localparam int unsigned REG_STEP_MV = 100;
  localparam logic [REG_W-1:0] REG_TOP = REG_W'((REG_MAX_MV - REG_MIN_MV) / REG_STEP_MV);
  localparam logic [REG_W-1:0] REG_FLOOR = 4'h0;
  localparam int unsigned RF_LSB_UVPP = 13_020;

  localparam logic [DATA_W-1:0] LFSR_SEED = 8'h01;
  localparam logic [DATA_W-1:0] LFSR_TAPS = 8'hB8;

  function automatic int unsigned cyc_min(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int unsigned cyc_max(input int unsigned t_ns);
    int unsigned c;
    c = (t_ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_DELAY = 8'h02,
    ST_SLOT  = 8'h04,
    ST_GUARD = 8'h08,
    ST_SEND  = 8'h10,
    ST_HOLD  = 8'h20,
    ST_BUSY  = 8'h40,
    ST_ADJ   = 8'h80
  } rdc_state_t;

endpackage

// file: verilog/rdc_link_capture.sv
`timescale 1ns/100ps
module rdc_link_capture
  import rdc_pkg::*;
(
  input  wire logic             link_clk,
  input  wire logic             link_rst_b,
  input  wire logic             cmd_strobe,
  input  wire logic [CMD_W-1:0] cmd_code,
  output logic      [CMD_W-1:0] code_hold,
  output logic                  cmd_toggle
);

  logic [CMD_W-1:0] code_r;
  logic             tgl_r;

  // code is held until the next strobe so the far domain reads it stable
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      code_r <= '0;
      tgl_r  <= 1'b0;
    end else if (cmd_strobe) begin
      code_r <= cmd_code;
      tgl_r  <= ~tgl_r;
    end
  end

  assign code_hold  = code_r;
  assign cmd_toggle = tgl_r;

endmodule

// file: bench/rdc_host_model.sv
`timescale 1ns/100ps
module rdc_host_model
  import rdc_pkg::*;
(
  input  wire logic             link_clk,
  input  wire logic             link_rst_b,
  input  wire logic             go,
  input  wire logic [CMD_W-1:0] code,
  output logic                  cmd_strobe,
  output logic      [CMD_W-1:0] cmd_code
);
  logic go_r;
  // code churns between strobes so a stale value is never mistaken
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      go_r       <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_code   <= 6'h00;
    end else begin
      go_r       <= go;
      cmd_strobe <= go ^ go_r;
      cmd_code   <= (go ^ go_r) ? code : ~cmd_code;
    end
  end
endmodule

// file: bench/tb.sv
`timescale 1ns/100ps
module tb
  import rdc_pkg::*;
;
  logic ref_clk = 0, link_clk = 0, rst_b = 0, go = 0, nfc_mode = 0, osc_ready = 1;
  logic rx_enabled = 0, tx_enabled = 0, reg_ext_select = 0, ext_field_detect = 0;
  logic tx_data_done = 0, rail_margin_ok = 0, cmd_strobe, rf_field_on, rx_on;
  logic irq_nfc_event, irq_end_tx, force_txrx, cmd_reject;
  logic sen_line = 1, framing_en, squelch_on, transparent_on, cmd_busy;
  logic [DATA_W-1:0] mod_meas = 8'h00, mod_depth_result;
  logic [CMD_W-1:0]  code = 6'h00, cmd_code;
  logic [DATA_W-1:0] adc_sample = 8'h5A, adc_result;
  logic [REG_W-1:0]  reg_setting;
  int failures = 0, num_checks = 0;
  wire [5:0] obs = {cmd_reject, irq_nfc_event, irq_end_tx, rf_field_on, force_txrx, rx_on};
  always #5 ref_clk = ~ref_clk;
  always #6 link_clk = ~link_clk;
  rdc_host_model host_u (.link_clk, .link_rst_b(rst_b), .go, .code, .cmd_strobe, .cmd_code);
  rdc_sequencer #(.IDT_CYC(12), .RWF_CYC(8), .IRFG_CYC(15), .ADT_CYC(10), .ARFG_CYC(9),
    .GAS_CYC(14), .RXD_CYC(40), .ADC_CYC(10), .STEP_CYC(20), .SQL_CYC(10),
    .MOD_CYC(10)) dut_u (
    .ref_clk, .rst_b, .link_clk, .link_rst_b(rst_b), .cmd_strobe, .cmd_code,
    .serial_enable_line(sen_line), .nfc_mode, .osc_ready, .rx_enabled, .tx_enabled,
    .reg_ext_select, .ext_field_detect, .tx_data_done, .rail_margin_ok, .adc_sample,
    .mod_depth_meas(mod_meas), .rf_field_on, .tx_start(), .rx_on, .framing_en,
    .received_strength_indicator_clear(), .irq_nfc_event, .irq_end_tx, .adc_rf_select(), .adc_result,
    .squelch_on, .force_txrx, .reg_setting, .mod_depth_result, .ant_cal_active(),
    .transparent_on, .cmd_busy, .cmd_reject);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait on one observed output
  task automatic wait_for(input int i, input logic v);
    int n;
    for (n = 0; n < 3000 && obs[i] !== v; n++) @(negedge ref_clk);
    if (n == 3000) begin
      chk(8'h00, 8'h01, "timeout");
      end_sim;
    end
  endtask
  task automatic send(input logic [CMD_W-1:0] c);
    repeat (10) @(negedge ref_clk);
    code = c;
    go = ~go;
  endtask
  task automatic t_refuse;
    send(CMD_NFC_INIT); wait_for(5, 1'b1); chk(rf_field_on, 0, "field");
    send(6'h3F); wait_for(5, 1'b1); chk(reg_setting, 8'h0A, "reg");
  endtask
  task automatic t_mask;
    rx_enabled = 1;
    send(CMD_UNMASK_RX); wait_for(0, 1'b1);
    chk(framing_en, 1, "framing on");
    send(CMD_MASK_RX); wait_for(0, 1'b0);
    chk(framing_en, 0, "framing off");
    rx_enabled = 0;
    send(CMD_UNMASK_RX); wait_for(5, 1'b1); chk(rx_on, 0, "rx_on");
  endtask
  task automatic t_adc;
    send(CMD_ADC); repeat (9) @(negedge ref_clk);
    chk(cmd_busy, 1, "busy");
    repeat (21) @(negedge ref_clk);
    chk(cmd_busy, 0, "busy end");
    chk(adc_result, 8'h5A, "adc");
    adc_sample = 8'hA5;
    send(CMD_MEAS_RF); repeat (30) @(negedge ref_clk);
    chk(adc_result, 8'hA5, "rf");
  endtask
  task automatic t_nfc;
    nfc_mode = 1;
    rx_enabled = 1;
    send(CMD_NFC_RESP0); wait_for(2, 1'b1);
    repeat (12) @(negedge ref_clk);
    tx_data_done = 1;
    @(negedge ref_clk) tx_data_done = 0;
    repeat (11) @(negedge ref_clk);
    chk(rf_field_on, 1, "hold");
    wait_for(3, 1'b1); chk(rf_field_on, 0, "off");
    send(CMD_UNMASK_RX); wait_for(0, 1'b1);
    ext_field_detect = 1;
    send(CMD_NFC_INIT); wait_for(4, 1'b1); chk(rf_field_on, 0, "skip");
    ext_field_detect = 0;
    nfc_mode = 0;
  endtask
  task automatic t_adj;
    reg_ext_select = 1;
    send(CMD_ADJ_REG); wait_for(5, 1'b1); chk(force_txrx, 0, "force");
    reg_ext_select = 0;
    send(CMD_ADJ_REG); wait_for(1, 1'b1); wait_for(1, 1'b0);
    chk(reg_setting, 8'h00, "floor");
  endtask
  task automatic t_misc;
    tx_enabled = 1;
    rx_enabled = 1;
    send(CMD_SQUELCH); repeat (30) @(negedge ref_clk);
    chk(squelch_on, 1, "squelch");
    send(CMD_CLR_SQUELCH); repeat (15) @(negedge ref_clk);
    chk(squelch_on, 0, "clear squelch");
    mod_meas = 8'h3C;
    send(CMD_CAL_MOD); repeat (30) @(negedge ref_clk);
    chk(mod_depth_result, 8'h3C, "mod depth");
    send(CMD_TRANSP); repeat (15) @(negedge ref_clk);
    chk(transparent_on, 0, "transp armed");
    sen_line = 0;
    repeat (6) @(negedge ref_clk);
    chk(transparent_on, 1, "transp on");
    sen_line = 1;
    repeat (6) @(negedge ref_clk);
    chk(transparent_on, 0, "transp off");
    tx_enabled = 0;
    rx_enabled = 0;
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_b = 1;
    chk(reg_setting, 8'h0A, "reset");
    t_refuse;
    t_mask;
    t_adc;
    t_nfc;
    t_adj;
    t_misc;
    end_sim;
  end
endmodule
